// >>> rtl/mssa_consts.svh
// Function
// - Logical address is high switch nibble over low switch nibble, 1 to FFh.
// - Decode a 64-byte window at logical address times 64 plus 49152.
// - Failure lamp lights while the system-failure line is asserted.
// - Bus-activity lamp stretches each access to about 0.2 s, stays lit.
// - Error lamp lights while an error condition is pending.
// - Drive a four-character display with status, errors and closed relays.
// - Show ready when no error is pending and all matrix relays are open.
// - With matrix relays closed and no error, scroll closed relay coordinates.
// - With an error pending, scroll E, error number, then message text.
// - Remove the error message once the controller reads the last error.
// - Control 128 matrix relays and 20 configuration relays, one output each.
// - At power-up open all relays, configure two separate 4x16 matrices.
// - At power-up clear macros, non-buffered mode, settle/wordy/update on.
// - Open released matrix relays before closing newly closed ones.
`ifndef MSSA_CONSTS_SVH
`define MSSA_CONSTS_SVH
`define MSSA_WIN_SHIFT 6
`define MSSA_WIN_BASE 16'hC000
`define MSSA_REG_RELAY0 6'h00
`define MSSA_REG_CFG0 6'h10
`define MSSA_REG_CFG1 6'h12
`define MSSA_REG_MODE 6'h14
`define MSSA_REG_ERRNUM 6'h16
`define MSSA_REG_ERRMSG 6'h18
`define MSSA_REG_APPLY 6'h1A
`define MSSA_REG_STAT 6'h1C
`define MSSA_REG_IRQ_STAT 6'h1E
`define MSSA_REG_IRQ_MASK 6'h20
`define MSSA_REG_ERRRD 6'h22
`define MSSA_CFG_RESET 20'h00000
`define MSSA_MODE_RESET 8'h0B
`define MSSA_MODE_SETTLE 0
`define MSSA_MODE_WORDY 1
`define MSSA_MODE_SECBUF 2
`define MSSA_MODE_UPDATE 3
`define MSSA_MODE_BUFFERED 4
`define MSSA_MODE_MACROCLR 5
`define MSSA_CLK_HZ 10000000
`define MSSA_STRETCH_MS 200
`define MSSA_STRETCH_CYC ((`MSSA_CLK_HZ / 1000) * `MSSA_STRETCH_MS)
`define MSSA_DWELL_MS 500
`define MSSA_DWELL_CYC ((`MSSA_CLK_HZ / 1000) * `MSSA_DWELL_MS)
`define MSSA_BREAK_US 1000
`define MSSA_BREAK_CYC ((`MSSA_CLK_HZ / 1000000) * `MSSA_BREAK_US)
`define MSSA_IRQ_ERR 0
`define MSSA_IRQ_APPLIED 1
`define MSSA_CH_SPACE 8'h20
`define MSSA_CH_R 8'h52
`define MSSA_CH_D 8'h44
`define MSSA_CH_Y 8'h59
`define MSSA_CH_E 8'h45
`endif

// >>> rtl/mssa_pkg.sv
package mssa_pkg;
  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } mssa_bus_req_type;
  typedef enum logic [1:0] {
    MSSA_SW_IDLE = 2'b00,
    MSSA_SW_BREAK = 2'b01,
    MSSA_SW_MAKE = 2'b10
  } mssa_sw_state_type;
  typedef enum logic [1:0] {
    MSSA_DS_READY = 2'b00,
    MSSA_DS_RELAY = 2'b01,
    MSSA_DS_ERROR = 2'b10
  } mssa_disp_state_type;
endpackage : mssa_pkg

// >>> rtl/mssa_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mssa_consts.svh"
module mssa_top
  import mssa_pkg::*;
#(
  parameter int STRETCH_CYC = `MSSA_STRETCH_CYC,
  parameter int DWELL_CYC = `MSSA_DWELL_CYC
) (
  input wire logic clk_sys_i, // System clock
  input wire logic nrst_i, // Async reset, low
  input wire logic [3:0] address_high_digit_switch_i, // Rotary switch, high
  input wire logic [3:0] address_low_digit_switch_i, // Rotary switch, low
  input wire logic [15:0] bus_addr_i, // A16 byte address
  input wire logic [15:0] bus_wdata_i, // Write data
  input wire logic bus_wr_i, // Write strobe
  input wire logic bus_rd_i, // Read strobe
  output logic [15:0] bus_rdata_o, // Read data
  input wire logic sysfail_i, // System-failure line asserted
  output logic failure_indicator_o, // Failure lamp
  output logic bus_activity_indicator_o, // Activity lamp
  output logic error_indicator_o, // Error lamp
  output logic [31:0] display_o, // Four characters
  output logic [127:0] matrix_relay_o, // Matrix relay drives
  output logic [19:0] cfg_relay_o, // Configuration relay drives
  output logic [7:0] mode_o, // Mode settings
  output logic [7:0] logical_address_o, // Logical address
  output logic irq_o // Interrupt, high
);
  // ****************************************
  // Switch sync and window decode
  // ****************************************
  // A code counts only once two stages agree, so a half-turned switch never latches
  logic [7:0] sw_s1_q, sw_s2_q, sw_s3_q, la_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_s1_q <= 8'h00;
      sw_s2_q <= 8'h00;
      sw_s3_q <= 8'h00;
      la_q <= 8'h00;
    end else begin
      sw_s1_q <= {address_high_digit_switch_i, address_low_digit_switch_i};
      sw_s2_q <= sw_s1_q;
      sw_s3_q <= sw_s2_q;
      if (sw_s2_q == sw_s3_q) begin
        la_q <= sw_s3_q;
      end
    end
  end
  assign logical_address_o = la_q;
  logic [15:0] win_base;
  logic hit;
  mssa_bus_req_type req;
  assign win_base = 16'(({8'h00, la_q} << `MSSA_WIN_SHIFT) + `MSSA_WIN_BASE);
  // Address 0 is reserved for the commander, so never decode it
  assign hit = (la_q != 8'h00) && (bus_addr_i[15:6] == win_base[15:6]);
  assign req = '{addr: bus_addr_i[5:0], wdata: bus_wdata_i,
                 wr: bus_wr_i & hit, rd: bus_rd_i & hit};

  // ****************************************
  // Registers
  // ****************************************
  logic [127:0] target_q, relay_q;
  logic [19:0] cfg_q;
  logic [7:0] mode_q;
  logic [7:0] errnum_q;
  logic [15:0] errmsg_q;
  logic err_pend_q;
  logic [1:0] irq_stat_q, irq_mask_q;
  logic apply_req;
  logic applied_ev;
  logic err_ev;
  assign apply_req = req.wr && req.addr == `MSSA_REG_APPLY && req.wdata[0];
  assign err_ev = req.wr && req.addr == `MSSA_REG_ERRNUM;
  generate
    for (genvar g = 0; g < 8; g++) begin : g_tgt
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          target_q[g*16 +: 16] <= 16'h0000;
        end else if (req.wr && req.addr == 6'(`MSSA_REG_RELAY0 + 2*g)) begin
          target_q[g*16 +: 16] <= req.wdata;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q <= `MSSA_CFG_RESET;
      mode_q <= `MSSA_MODE_RESET;
    end else begin
      if (req.wr && req.addr == `MSSA_REG_CFG0) begin
        cfg_q[15:0] <= req.wdata;
      end
      if (req.wr && req.addr == `MSSA_REG_CFG1) begin
        cfg_q[19:16] <= req.wdata[3:0];
      end
      if (req.wr && req.addr == `MSSA_REG_MODE) begin
        mode_q <= req.wdata[7:0];
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      errnum_q <= 8'h00;
      errmsg_q <= 16'h0000;
      err_pend_q <= 1'b0;
    end else begin
      if (err_ev) begin
        errnum_q <= req.wdata[7:0];
        err_pend_q <= 1'b1;
      end else if (req.rd && req.addr == `MSSA_REG_ERRRD) begin
        err_pend_q <= 1'b0;
      end
      if (req.wr && req.addr == `MSSA_REG_ERRMSG) begin
        errmsg_q <= req.wdata;
      end
    end
  end
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  assign irq_set[`MSSA_IRQ_ERR] = err_ev;
  assign irq_set[`MSSA_IRQ_APPLIED] = applied_ev;
  assign irq_clr = (req.wr && req.addr == `MSSA_REG_IRQ_STAT) ? req.wdata[1:0] : 2'b00;
  generate
    for (genvar b = 0; b < 2; b++) begin : g_irq
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          irq_stat_q[b] <= 1'b0;
        end else if (irq_set[b]) begin
          // Set wins over a same-cycle clear
          irq_stat_q[b] <= 1'b1;
        end else if (irq_clr[b]) begin
          irq_stat_q[b] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_mask_q <= 2'b00;
    end else if (req.wr && req.addr == `MSSA_REG_IRQ_MASK) begin
      irq_mask_q <= req.wdata[1:0];
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // Break-before-make sequencer
  // ****************************************
  // Released relays open first, so no two paths are ever joined while switching
  mssa_sw_state_type sw_q;
  logic [15:0] brk_cnt_q;
  logic [127:0] pend_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_q <= MSSA_SW_IDLE;
      relay_q <= 128'h0;
      pend_q <= 128'h0;
      brk_cnt_q <= 16'h0000;
      applied_ev <= 1'b0;
    end else begin
      applied_ev <= 1'b0;
      case (sw_q)
        MSSA_SW_IDLE: begin
          // Apply requests during a transfer are dropped, not queued
          if (apply_req) begin
            pend_q <= target_q;
            relay_q <= relay_q & target_q;
            brk_cnt_q <= 16'(`MSSA_BREAK_CYC);
            sw_q <= MSSA_SW_BREAK;
          end
        end
        MSSA_SW_BREAK: begin
          // Settle wait off skips the contact release time
          if (brk_cnt_q <= 16'h0001 || !mode_q[`MSSA_MODE_SETTLE]) begin
            sw_q <= MSSA_SW_MAKE;
          end else begin
            brk_cnt_q <= brk_cnt_q - 16'h0001;
          end
        end
        MSSA_SW_MAKE: begin
          relay_q <= pend_q;
          applied_ev <= 1'b1;
          sw_q <= MSSA_SW_IDLE;
        end
        default: sw_q <= MSSA_SW_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      matrix_relay_o <= 128'h0;
      cfg_relay_o <= `MSSA_CFG_RESET;
      mode_o <= `MSSA_MODE_RESET;
    end else begin
      matrix_relay_o <= relay_q;
      cfg_relay_o <= cfg_q;
      mode_o <= mode_q;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Only the error readback has a side effect
  logic [15:0] rd_d;
  always_comb begin
    rd_d = 16'h0000;
    if (req.addr < `MSSA_REG_CFG0) begin
      rd_d = target_q[{req.addr[3:1], 4'h0} +: 16];
    end else begin
      case (req.addr)
        `MSSA_REG_CFG0: rd_d = cfg_q[15:0];
        `MSSA_REG_CFG1: rd_d = {12'h000, cfg_q[19:16]};
        `MSSA_REG_MODE: rd_d = {8'h00, mode_q};
        `MSSA_REG_ERRNUM: rd_d = {8'h00, errnum_q};
        `MSSA_REG_ERRMSG: rd_d = errmsg_q;
        `MSSA_REG_STAT: rd_d = {13'h0000, sw_q != MSSA_SW_IDLE, err_pend_q, |relay_q};
        `MSSA_REG_IRQ_STAT: rd_d = {14'h0000, irq_stat_q};
        `MSSA_REG_IRQ_MASK: rd_d = {14'h0000, irq_mask_q};
        `MSSA_REG_ERRRD: rd_d = {8'h00, errnum_q};
        default: rd_d = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_rdata_o <= 16'h0000;
    end else begin
      bus_rdata_o <= req.rd ? rd_d : 16'h0000;
    end
  end

  // ****************************************
  // Indicators
  // ****************************************
  // Lamp follows the filtered line, so a one-clock glitch never shows
  logic sf_s1_q, sf_s2_q, sf_s3_q;
  logic [23:0] act_cnt_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sf_s1_q <= 1'b0;
      sf_s2_q <= 1'b0;
      sf_s3_q <= 1'b0;
      failure_indicator_o <= 1'b0;
      error_indicator_o <= 1'b0;
    end else begin
      sf_s1_q <= sysfail_i;
      sf_s2_q <= sf_s1_q;
      sf_s3_q <= sf_s2_q;
      if (sf_s2_q == sf_s3_q) begin
        failure_indicator_o <= sf_s3_q;
      end
      error_indicator_o <= err_pend_q;
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_cnt_q <= 24'h000000;
      bus_activity_indicator_o <= 1'b0;
    end else begin
      // Retrigger keeps the lamp lit under back-to-back accesses
      if (req.wr || req.rd) begin
        act_cnt_q <= 24'(STRETCH_CYC);
      end else if (act_cnt_q != 24'h000000) begin
        act_cnt_q <= act_cnt_q - 24'h000001;
      end
      bus_activity_indicator_o <= req.wr || req.rd || act_cnt_q != 24'h000000;
    end
  end

  // ****************************************
  // Display sequencer
  // ****************************************
  mssa_disp_state_type ds_q;
  logic [23:0] dwell_q;
  logic [6:0] scan_q;
  logic [1:0] estep_q;
  logic [31:0] disp_d;
  logic tick;
  assign tick = (dwell_q == 24'h000000);
  // Row is the high three index bits, column the low four
  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'hA) ? 8'(8'h30 + n) : 8'(8'h37 + n);
  endfunction : hexc
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ds_q <= MSSA_DS_READY;
      dwell_q <= 24'h000000;
      scan_q <= 7'h00;
      estep_q <= 2'b00;
    end else begin
      dwell_q <= tick ? 24'(DWELL_CYC - 1) : dwell_q - 24'h000001;
      if (err_pend_q) begin
        ds_q <= MSSA_DS_ERROR;
      end else if (|relay_q) begin
        ds_q <= MSSA_DS_RELAY;
      end else begin
        ds_q <= MSSA_DS_READY;
      end
      if (ds_q != MSSA_DS_ERROR) begin
        estep_q <= 2'b00;
      end else if (tick) begin
        estep_q <= (estep_q == 2'b10) ? 2'b00 : estep_q + 2'b01;
      end
      // Skip open relays one per clock, hold on a closed one for a dwell
      if (ds_q == MSSA_DS_RELAY && (!relay_q[scan_q] || tick)) begin
        scan_q <= scan_q + 7'h01;
      end
    end
  end
  always_comb begin
    disp_d = {`MSSA_CH_R, `MSSA_CH_D, `MSSA_CH_Y, `MSSA_CH_SPACE};
    case (ds_q)
      MSSA_DS_READY: disp_d = {`MSSA_CH_R, `MSSA_CH_D, `MSSA_CH_Y, `MSSA_CH_SPACE};
      MSSA_DS_RELAY: disp_d = {hexc({1'b0, scan_q[6:4]}), 8'h2C, hexc(scan_q[3:0]),
                               `MSSA_CH_SPACE};
      MSSA_DS_ERROR: begin
        case (estep_q)
          2'b00: disp_d = {`MSSA_CH_E, {3{`MSSA_CH_SPACE}}};
          2'b01: disp_d = {hexc(errnum_q[7:4]), hexc(errnum_q[3:0]), {2{`MSSA_CH_SPACE}}};
          default: disp_d = {hexc(errmsg_q[15:12]), hexc(errmsg_q[11:8]),
                             hexc(errmsg_q[7:4]), hexc(errmsg_q[3:0])};
        endcase
      end
      default: disp_d = {`MSSA_CH_R, `MSSA_CH_D, `MSSA_CH_Y, `MSSA_CH_SPACE};
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      display_o <= {`MSSA_CH_R, `MSSA_CH_D, `MSSA_CH_Y, `MSSA_CH_SPACE};
    end else if (ds_q != MSSA_DS_RELAY || relay_q[scan_q]) begin
      display_o <= disp_d;
    end
  end
endmodule : mssa_top
`default_nettype wire

// >>> dv/mssa_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "mssa_consts.svh"
module mssa_chk
  import mssa_pkg::*;
#(
  parameter int STRETCH_CYC = 20,
  parameter int DWELL_CYC = 8
) (
  input wire logic clk_sys_i, // Clock
  input wire logic nrst_i, // Reset, low
  input wire logic [3:0] address_high_digit_switch_i, // High digit
  input wire logic [3:0] address_low_digit_switch_i, // Low digit
  input wire logic [15:0] bus_addr_i, // Address
  input wire logic [15:0] bus_wdata_i, // Write data
  input wire logic bus_wr_i, // Write strobe
  input wire logic bus_rd_i, // Read strobe
  input wire logic [15:0] bus_rdata_o, // Read data
  input wire logic sysfail_i, // Failure line
  input wire logic failure_indicator_o, // Failure lamp
  input wire logic bus_activity_indicator_o, // Activity lamp
  input wire logic error_indicator_o, // Error lamp
  input wire logic [31:0] display_o, // Display
  input wire logic [127:0] matrix_relay_o, // Matrix drives
  input wire logic [19:0] cfg_relay_o, // Config drives
  input wire logic [7:0] mode_o, // Mode
  input wire logic [7:0] logical_address_o, // Address
  input wire logic irq_o // Interrupt
);
  // ********************************
  // Window decode and idle counter
  // ********************************
  logic hit;
  logic [31:0] idle_q;
  assign hit = (logical_address_o != 8'h00) &&
               (bus_addr_i[15:6] == 10'h300 + {2'h0, logical_address_o});
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_q <= 32'h00000000;
    end else if ((bus_wr_i || bus_rd_i) && hit) begin
      idle_q <= 32'h00000000;
    end else if (idle_q != 32'hFFFFFFFF) begin
      idle_q <= idle_q + 32'h00000001;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_acc; (bus_wr_i || bus_rd_i) && hit; endsequence
  sequence s_err_log; bus_wr_i && hit && bus_addr_i[5:0] == `MSSA_REG_ERRNUM; endsequence
  sequence s_err_rd; bus_rd_i && hit && bus_addr_i[5:0] == `MSSA_REG_ERRRD; endsequence
  AST_LA: assert property ($stable({address_high_digit_switch_i, address_low_digit_switch_i})[*6]
    |-> logical_address_o == {address_high_digit_switch_i, address_low_digit_switch_i})
    else $error("logical address differs from switches");
  AST_RDATA_IDLE: assert property (!($past(bus_rd_i) && $past(hit)) |-> bus_rdata_o == 16'h0000)
    else $error("read data without a hit read");
  AST_ACT_ON: assert property (s_acc |=> bus_activity_indicator_o)
    else $error("activity lamp missed an access");
  AST_ACT_OFF: assert property (idle_q > STRETCH_CYC + 2 |-> !bus_activity_indicator_o)
    else $error("activity lamp stretched too long");
  AST_FAIL_ON: assert property (sysfail_i[*6] |-> failure_indicator_o)
    else $error("failure lamp dark while line asserted");
  AST_FAIL_OFF: assert property (!sysfail_i[*6] |-> !failure_indicator_o)
    else $error("failure lamp lit while line idle");
  AST_ERR_ON: assert property (s_err_log |-> ##[1:3] error_indicator_o)
    else $error("error lamp missed a logged error");
  AST_ERR_CLR: assert property (s_err_rd ##1
    !(bus_wr_i && hit && bus_addr_i[5:0] == `MSSA_REG_ERRNUM) |=> !error_indicator_o)
    else $error("error not cleared by readback");
  AST_RDY: assert property ((!error_indicator_o && matrix_relay_o == 128'h0)[*8]
    |-> display_o == 32'h52445920) else $error("ready message missing");
  AST_PWRUP: assert property ($rose(nrst_i) |-> mode_o == 8'h0B && matrix_relay_o == 128'h0
    && cfg_relay_o == 20'h00000) else $error("power-up state wrong");
  AST_BBM: assert property ($changed(matrix_relay_o) |->
    ((matrix_relay_o & ~$past(matrix_relay_o)) == 128'h0) ||
    (($past(matrix_relay_o) & ~matrix_relay_o) == 128'h0)) else $error("open and close at once");
endmodule : mssa_chk
bind mssa_top mssa_chk #(.STRETCH_CYC(STRETCH_CYC), .DWELL_CYC(DWELL_CYC)) u_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .address_high_digit_switch_i(address_high_digit_switch_i),
  .address_low_digit_switch_i(address_low_digit_switch_i),
  .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
  .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .sysfail_i(sysfail_i),
  .failure_indicator_o(failure_indicator_o), .bus_activity_indicator_o(bus_activity_indicator_o),
  .error_indicator_o(error_indicator_o), .display_o(display_o),
  .matrix_relay_o(matrix_relay_o), .cfg_relay_o(cfg_relay_o), .mode_o(mode_o),
  .logical_address_o(logical_address_o), .irq_o(irq_o));
`default_nettype wire

// >>> dv/mssa_bus_bfm.sv
`timescale 1ns/1ps
`default_nettype none
module mssa_bus_bfm (
  input wire logic clk_sys_i, // Clock
  output logic [15:0] bus_addr_o, // Address
  output logic [15:0] bus_wdata_o, // Write data
  output logic bus_wr_o, // Write strobe
  output logic bus_rd_o, // Read strobe
  input wire logic [15:0] bus_rdata_i // Read data
);
  // ********************************
  // Commander side of the register port
  // ********************************
  initial begin
    bus_addr_o = 16'h0000;
    bus_wdata_o = 16'h0000;
    bus_wr_o = 1'b0;
    bus_rd_o = 1'b0;
  end
  // Released lines invert, so a stale value never looks held
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    bus_addr_o <= a;
    bus_wdata_o <= d;
    bus_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    bus_wr_o <= 1'b0;
    bus_addr_o <= ~a;
    bus_wdata_o <= ~d;
    @(posedge clk_sys_i);
  endtask : write
  task automatic read(input logic [15:0] a, output logic [15:0] d);
    bus_addr_o <= a;
    bus_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    bus_rd_o <= 1'b0;
    bus_addr_o <= ~a;
    @(posedge clk_sys_i);
    d = bus_rdata_i;
  endtask : read
endmodule : mssa_bus_bfm
`default_nettype wire

// >>> dv/mssa_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mssa_top_tb import mssa_pkg::*;;
  // ********************************
  // Bench, short counts for speed
  // ********************************
  localparam logic [7:0] LA = 8'h15; // Unique in the system
  localparam logic [15:0] B = 16'hC000 + {2'h0, LA, 6'h00};
  localparam logic [31:0] RDY = 32'h52445920;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sysfail_i = 1'b0;
  logic [3:0] sw_hi = 4'h1;
  logic [3:0] sw_lo = 4'h5;
  logic [15:0] bus_addr, bus_wdata, bus_rdata, d;
  logic bus_wr, bus_rd, fail_led, act_led, err_led, irq;
  logic [31:0] disp;
  logic [127:0] relay;
  logic [19:0] cfg;
  logic [7:0] mode, la;
  int n_fail = 0;
  int num_checks = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  mssa_top #(.STRETCH_CYC(20), .DWELL_CYC(8)) uut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .address_high_digit_switch_i(sw_hi), .address_low_digit_switch_i(sw_lo),
    .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd),
    .bus_rdata_o(bus_rdata), .sysfail_i(sysfail_i), .failure_indicator_o(fail_led),
    .bus_activity_indicator_o(act_led), .error_indicator_o(err_led), .display_o(disp),
    .matrix_relay_o(relay), .cfg_relay_o(cfg), .mode_o(mode), .logical_address_o(la),
    .irq_o(irq));
  mssa_bus_bfm bm (.clk_sys_i(clk_sys_i), .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata),
    .bus_wr_o(bus_wr), .bus_rd_o(bus_rd), .bus_rdata_i(bus_rdata));
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic poll(input logic [31:0] exp, input string m);
    for (int i = 0; i < 64 && disp !== exp; i++) @(posedge clk_sys_i);
    chk(disp, exp, m);
  endtask : poll
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk_sys_i);
    chk(irq, 1'b1, "irq");
  endtask : wait_irq
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    chk(la, LA, "address");
    chk(mode, 8'h0B, "mode");
    chk(relay, 128'h0, "relays");
    chk(cfg, 20'h0, "config");
    chk(disp, RDY, "ready");
    chk({fail_led, err_led}, 2'b00, "lamps");
    bm.write(B + 16'h0014, 16'h000A);
    chk(act_led, 1'b1, "activity");
    bm.write(B + 16'h0054, 16'h00FF);
    chk(mode, 8'h0A, "miss write");
    bm.read(B + 16'h0014, d);
    chk(d, 16'h000A, "readback");
    bm.read(B + 16'h003E, d);
    chk(d, 16'h0000, "unmapped");
    repeat (25) @(posedge clk_sys_i);
    chk(act_led, 1'b0, "activity off");
    sysfail_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk(fail_led, 1'b1, "failure on");
    sysfail_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk(fail_led, 1'b0, "failure off");
    bm.write(B + 16'h0012, 16'h000F);
    @(posedge clk_sys_i);
    chk(cfg, 20'hF0000, "config high");
    bm.write(B + 16'h0020, 16'h0003);
    bm.write(B, 16'h0003);
    bm.write(B + 16'h001A, 16'h0001);
    wait_irq(50);
    chk(relay, 128'h3, "closed");
    poll(32'h302C3120, "coordinates");
    bm.write(B + 16'h001E, 16'h0002);
    @(posedge clk_sys_i);
    chk(irq, 1'b0, "irq clear");
    bm.write(B + 16'h0014, 16'h000B);
    bm.write(B, 16'h0006);
    bm.write(B + 16'h001A, 16'h0001);
    repeat (20) @(posedge clk_sys_i);
    chk(relay, 128'h2, "break first");
    bm.read(B + 16'h001C, d);
    chk(d, 16'h0005, "status busy");
    wait_irq(11000);
    chk(relay, 128'h6, "make after");
    bm.write(B + 16'h0018, 16'h1234);
    bm.write(B + 16'h0016, 16'h0007);
    @(posedge clk_sys_i);
    chk({err_led, irq}, 2'b11, "error lamp");
    poll(32'h45202020, "letter");
    poll(32'h30372020, "number");
    poll(32'h31323334, "message");
    bm.read(B + 16'h0022, d);
    chk(d, 16'h0007, "error read");
    @(posedge clk_sys_i);
    chk(err_led, 1'b0, "error cleared");
    bm.write(B + 16'h001E, 16'h0003);
    bm.write(B, 16'h0000);
    bm.write(B + 16'h001A, 16'h0001);
    wait_irq(11000);
    poll(RDY, "ready again");
    sw_hi <= 4'h0;
    sw_lo <= 4'hA;
    repeat (6) @(posedge clk_sys_i);
    chk(la, 8'h0A, "new address");
    bm.read(16'hC280 + 16'h0014, d);
    chk(d, 16'h000B, "moved window");
    bm.read(B + 16'h0014, d);
    chk(d, 16'h0000, "old window");
    conclude();
  end
endmodule : mssa_top_tb
`default_nettype wire
